// file: verilog/mcu_interrupt_enable_flag_unit.sv
// interrupt enable, flag and edge-select unit with an apb slave
//
// Function
// - timer A overflow sets flag bit 0
// - port-B input change sets flag bit 1
// - selected external edge sets flag bit 2
// - timer B underflow sets flag bit 3
// - watchdog timeout sets flag bit 6
// - low-voltage event sets flag bit 4
// - flags stay set until firmware writes zero
// - flag reads zero where enable is clear
// - enable register holds six source enables
// - second enable bit 4 gates nvm done for the core request only, not irq
// - ext select makes pin zero external input
// - edge codes: reserved, rise, fall, both
// - global enable permits or blocks the core request only, not irq
// - nvm write done sets second flag bit 4
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module mcu_interrupt_enable_flag_unit
  import irq_unit_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic                clkEn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [DATA_W-1:0]   pwdata,
  output logic      [DATA_W-1:0]   prdata,
  output logic                     pready,
  output logic                     pslverr,
  // event sources, one-cycle pulses except the port-B pin levels
  input  wire logic                tmrAOverflow,
  input  wire logic                tmrBUnderflow,
  input  wire logic                watchdogTimeout,
  input  wire logic                lowVoltageEvt,
  input  wire logic                nvmWriteDone,
  input  wire logic [PORTB_W-1:0]  portbIn,
  // outputs
  output logic                     coreIrqReq,
  output logic                     irq,
  output logic                     portbPinZeroExt
);

  // ************************************************************
  // state
  // ************************************************************
  apb_state_t          state_q, state_d;
  logic [DATA_W-1:0]   prdata_q, prdata_d;
  logic                pready_q, pready_d;
  logic                pslverr_q, pslverr_d;

  logic [7:0]          enable_q, enable_d;
  logic [7:0]          flags_q, flags_d;
  logic [7:0]          enable2_q, enable2_d;
  logic [7:0]          flags2_q, flags2_d;
  logic                extSel_q, extSel_d;
  logic [1:0]          edgeSel_q, edgeSel_d;
  logic                gie_q, gie_d;
  logic [7:0]          status_q, status_d;
  logic [7:0]          mask_q, mask_d;
  logic [PORTB_W-1:0]  pbPrev_q, pbPrev_d;
  logic                pbValid_q, pbValid_d;
  logic                coreIrq_q, coreIrq_d;
  logic                irq_q, irq_d;

  // ************************************************************
  // event detection
  // ************************************************************
  logic [PORTB_W-1:0]  pbChg;
  logic                pbChange;
  logic                extRise;
  logic                extFall;
  logic                extEdge;
  logic [7:0]          evt;
  logic [7:0]          evt2;
  logic [7:0]          evtStat;
  logic                anyFlag;
  logic                anyStatus;

  genvar gi;
  generate
    for (gi = 0; gi < PORTB_W; gi++) begin : g_pbchg
      if (gi == 0) begin : g_pin0
        // pin zero is no longer plain i/o while it is the ext input
        assign pbChg[gi] = pbValid_q & ~extSel_q &
                           (portbIn[gi] ^ pbPrev_q[gi]);
      end else begin : g_pinx
        assign pbChg[gi] = pbValid_q &
                           (portbIn[gi] ^ pbPrev_q[gi]);
      end
    end
  endgenerate

  assign pbChange = |pbChg;
  assign extRise  = ~pbPrev_q[0] & portbIn[0];
  assign extFall  = pbPrev_q[0] & ~portbIn[0];

  // the request follows the gated view that firmware reads back
  assign anyFlag   = |(flags_q & enable_q) |
                     |(flags2_q & enable2_q);
  assign anyStatus = |(status_q & mask_q);

  always_comb begin
    extEdge = 1'b0;
    case (edgeSel_q)
      EDGE_RISE: extEdge = extRise;
      EDGE_FALL: extEdge = extFall;
      EDGE_BOTH: extEdge = extRise | extFall;
      default:   extEdge = 1'b0; // reserved code never fires
    endcase
    extEdge = extEdge & extSel_q & pbValid_q;
  end

  always_comb begin
    evt                 = 8'h00;
    evt[BIT_TMR_A]      = tmrAOverflow;
    evt[BIT_PORTB]      = pbChange;
    evt[BIT_EXT]        = extEdge;
    evt[BIT_TMR_B]      = tmrBUnderflow;
    evt[BIT_LOW_V]      = lowVoltageEvt;
    evt[BIT_WDOG]       = watchdogTimeout;
    evt2                = 8'h00;
    evt2[BIT_NVM]       = nvmWriteDone;
    evtStat             = evt;
    evtStat[STAT_NVM]   = nvmWriteDone;
  end

  // ************************************************************
  // apb decode
  // ************************************************************
  logic [7:0]  wordIdx;
  logic        aligned;
  logic        hit;
  logic        wrDone;
  logic [7:0]  wdata;
  logic [7:0]  rdMux;

  assign wordIdx = paddr[ADDR_W-1:2];
  // a misaligned word is refused, never aliased onto a neighbour
  assign aligned = (paddr[1:0] == 2'h0);
  assign wdata   = pwdata[7:0];
  // a write lands only on the edge that completes the access
  assign wrDone  = psel & penable & pwrite & pready_q & ~pslverr_q;

  always_comb begin
    hit   = aligned;
    rdMux = 8'h00;
    case (wordIdx)
      IDX_ENABLE:  rdMux = enable_q;
      IDX_FLAGS:   rdMux = flags_q & enable_q;
      IDX_ENABLE2: rdMux = enable2_q;
      IDX_FLAGS2:  rdMux = flags2_q & enable2_q;
      IDX_EDGE: begin
        rdMux[BIT_EXT_SEL] = extSel_q;
        rdMux[1:0]         = edgeSel_q;
      end
      IDX_CTRL:    rdMux[BIT_GIE] = gie_q;
      IDX_STATUS:  rdMux = status_q;
      IDX_MASK:    rdMux = mask_q;
      default:     hit = 1'b0;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_d   = state_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    case (state_q)
      AP_IDLE: begin
        if (psel && penable) begin
          // one wait state, answer registered
          state_d   = AP_ACK;
          pready_d  = 1'b1;
          pslverr_d = ~hit;
          prdata_d  = {{(DATA_W-8){1'b0}}, hit ? rdMux : 8'h00};
        end
      end
      AP_ACK: begin
        state_d  = AP_IDLE;
      end
      default: begin
        state_d  = AP_IDLE;
      end
    endcase
  end

  // ************************************************************
  // register file, flags and requests
  // ************************************************************
  always_comb begin
    enable_d  = enable_q;
    enable2_d = enable2_q;
    extSel_d  = extSel_q;
    edgeSel_d = edgeSel_q;
    gie_d     = gie_q;
    mask_d    = mask_q;
    flags_d   = flags_q;
    flags2_d  = flags2_q;
    status_d  = status_q;

    if (wrDone) begin
      case (wordIdx)
        IDX_ENABLE:  enable_d = wdata & ENABLE_MASK;
        IDX_ENABLE2: enable2_d = wdata & ENABLE2_MASK;
        IDX_EDGE: begin
          extSel_d  = wdata[BIT_EXT_SEL];
          edgeSel_d = wdata[1:0];
        end
        IDX_CTRL:    gie_d = wdata[BIT_GIE];
        IDX_MASK:    mask_d = wdata & STATUS_MASK;
        // writing one leaves a flag alone, zero clears it; a status bit clears on one
        IDX_FLAGS:   flags_d = flags_q & wdata;
        IDX_FLAGS2:  flags2_d = flags2_q & wdata;
        IDX_STATUS:  status_d = status_q & ~wdata;
        default:     ;
      endcase
    end

    // a new event outranks a clear in the same cycle
    // flags latch while disabled, only the read view is gated
    flags_d  = (flags_d | evt) & ENABLE_MASK;
    flags2_d = (flags2_d | evt2) & ENABLE2_MASK;
    status_d = (status_d | evtStat) & STATUS_MASK;

    // first sample after reset only primes the history
    pbPrev_d  = portbIn;
    pbValid_d = 1'b1;

    coreIrq_d = gie_q & anyFlag;
    irq_d     = anyStatus;
  end

  // ************************************************************
  // registers
  // ************************************************************
  // the handshake freezes with clkEn too, so a stalled access only waits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q   <= AP_IDLE;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (clkEn) begin
      state_q   <= state_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      enable_q  <= REG_RST;
      flags_q   <= REG_RST;
      enable2_q <= REG_RST;
      flags2_q  <= REG_RST;
      extSel_q  <= 1'b0;
      edgeSel_q <= EDGE_SEL_RST;
      gie_q     <= 1'b0;
      status_q  <= REG_RST;
      mask_q    <= REG_RST;
      pbPrev_q  <= '0;
      pbValid_q <= 1'b0;
      coreIrq_q <= 1'b0;
      irq_q     <= 1'b0;
    end else if (clkEn) begin
      enable_q  <= enable_d;
      flags_q   <= flags_d;
      enable2_q <= enable2_d;
      flags2_q  <= flags2_d;
      extSel_q  <= extSel_d;
      edgeSel_q <= edgeSel_d;
      gie_q     <= gie_d;
      status_q  <= status_d;
      mask_q    <= mask_d;
      pbPrev_q  <= pbPrev_d;
      pbValid_q <= pbValid_d;
      coreIrq_q <= coreIrq_d;
      irq_q     <= irq_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign coreIrqReq      = coreIrq_q;
  assign irq             = irq_q;
  assign portbPinZeroExt = extSel_q;

endmodule

`default_nettype wire

// file: verilog/irq_unit_pkg.sv
// constants for the interrupt enable, flag and edge-select unit
package irq_unit_pkg;

  // ************************************************************
  // bus shape
  // ************************************************************
  localparam int unsigned ADDR_W   = 10;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned PORTB_W  = 6;

  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam logic [7:0] IDX_ENABLE  = 8'h0e;
  localparam logic [7:0] IDX_FLAGS   = 8'h0f;
  localparam logic [7:0] IDX_ENABLE2 = 8'h17;
  localparam logic [7:0] IDX_EDGE    = 8'h18;
  localparam logic [7:0] IDX_FLAGS2  = 8'h1f;
  localparam logic [7:0] IDX_CTRL    = 8'h20;
  localparam logic [7:0] IDX_STATUS  = 8'h21;
  localparam logic [7:0] IDX_MASK    = 8'h22;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned BIT_TMR_A   = 0;
  localparam int unsigned BIT_PORTB   = 1;
  localparam int unsigned BIT_EXT     = 2;
  localparam int unsigned BIT_TMR_B   = 3;
  localparam int unsigned BIT_LOW_V   = 4;
  localparam int unsigned BIT_WDOG    = 6;
  localparam int unsigned BIT_NVM     = 4;
  localparam int unsigned BIT_EXT_SEL = 4;
  localparam int unsigned BIT_GIE     = 0;
  localparam int unsigned STAT_NVM    = 5;

  // implemented bits per register
  localparam logic [7:0] ENABLE_MASK  = 8'h5f;
  localparam logic [7:0] ENABLE2_MASK = 8'h10;
  localparam logic [7:0] STATUS_MASK  = 8'h7f;

  // ************************************************************
  // edge-select codes and reset values
  // ************************************************************
  localparam logic [1:0] EDGE_RISE    = 2'h1;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;
  localparam logic [1:0] EDGE_SEL_RST = EDGE_RISE;
  localparam logic [7:0] REG_RST      = 8'h00;

  typedef enum logic {AP_IDLE, AP_ACK} apb_state_t;

endpackage

// file: verif/irq_unit_asserts.sv
// port assertions for the interrupt enable and flag unit
`timescale 1ns/1ps
`default_nettype none
module irq_unit_asserts import irq_unit_pkg::*; (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        clkEn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        coreIrqReq,
  input wire logic        irq,
  input wire logic        portbPinZeroExt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // reset itself is the antecedent, so this one stays armed during reset
  rst_clear_a: assert property (disable iff (1'h0)
    sys_rst && clkEn |=> !coreIrqReq && !irq && !portbPinZeroExt)
    else $error("reset left outputs set");
  req_hold_a: assert property ($fell(coreIrqReq) |->
    $past(pready && pwrite, 2) || $past(sys_rst)) else $error("req fell");
  irq_hold_a: assert property ($fell(irq) |->
    $past(pready && pwrite, 2) || $past(sys_rst)) else $error("irq fell");
  ext_sel_a: assert property ($changed(portbPinZeroExt) |->
    $past(pready && pwrite) || $past(pready && pwrite, 2) || $past(sys_rst))
    else $error("ext select moved");
  rdy_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  rdy_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("access not two cycles");
  err_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused read data");
  hi_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data");
  cover property (pready && pslverr);
  cover property ($rose(coreIrqReq));
  cover property ($fell(irq));
endmodule
`default_nettype wire

// file: verif/tb_mcu_interrupt_enable_flag_unit.sv
// self-checking bench for the interrupt enable and flag unit
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_interrupt_enable_flag_unit import irq_unit_pkg::*; ();
  logic               ref_clk = 1'h0, sys_rst = 1'h1, clkEn = 1'h1;
  logic               psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [ADDR_W-1:0]  paddr = '0;
  logic [DATA_W-1:0]  pwdata = '0, prdata;
  logic               pready, pslverr, coreIrqReq, irq, pzExt, err;
  logic [4:0]         ev = '0;
  logic [PORTB_W-1:0] pb = '0;
  logic [7:0]         rd;
  int                 n_fail = 0, total_checks = 0;
  always #5 ref_clk = ~ref_clk;
  mcu_interrupt_enable_flag_unit dut (
    .ref_clk, .sys_rst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .coreIrqReq, .irq, .portbPinZeroExt(pzExt),
    .portbIn(pb), .tmrAOverflow(ev[0]), .tmrBUnderflow(ev[1]),
    .watchdogTimeout(ev[2]), .lowVoltageEvt(ev[3]), .nvmWriteDone(ev[4]));
  task chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] idx, wd);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rdc(input string nm, input logic [7:0] idx, exp);
    apb(1'h0, idx, 8'h00);
    chk(nm, rd, exp);
  endtask
  // one cycle only: a held level would set the flag on every edge
  task pulse(input logic [4:0] v);
    ev <= v;
    @(posedge ref_clk);
    ev <= '0;
  endtask
  // outputs lag the state by a cycle, so wait past that
  task outs(input string nm, input logic [2:0] exp);
    repeat (3) @(posedge ref_clk);
    chk(nm, {coreIrqReq, irq, pzExt}, exp);
  endtask
  task close_out;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task t_reset;
    rdc("enable", IDX_ENABLE, 8'h00);
    rdc("edge", IDX_EDGE, 8'h01);
    apb(1'h0, 8'h05, 8'h00);
    chk("refused", err, 1'h1);
    $display("test reset done");
  endtask
  task t_flags;
    pulse(5'h0f);
    pb <= 6'h02;
    rdc("masked", IDX_FLAGS, 8'h00);
    apb(1'h1, IDX_ENABLE, 8'hff);
    rdc("enable", IDX_ENABLE, 8'h5f);
    rdc("flags", IDX_FLAGS, 8'h5b);
    rdc("status", IDX_STATUS, 8'h5b);
    apb(1'h1, IDX_MASK, 8'h7f);
    rdc("mask", IDX_MASK, 8'h7f);
    outs("gie off", 3'h2);
    apb(1'h1, IDX_CTRL, 8'h01);
    rdc("ctrl", IDX_CTRL, 8'h01);
    outs("gie on", 3'h6);
    apb(1'h1, IDX_FLAGS, 8'hff);
    rdc("kept", IDX_FLAGS, 8'h5b);
    apb(1'h1, IDX_FLAGS, 8'h00);
    apb(1'h1, IDX_STATUS, 8'h7f);
    outs("cleared", 3'h0);
    $display("test flags done");
  endtask
  task t_nvm;
    pulse(5'h10);
    rdc("nvm off", IDX_FLAGS2, 8'h00);
    apb(1'h1, IDX_ENABLE2, 8'hff);
    rdc("nvm on", IDX_FLAGS2, 8'h10);
    rdc("nvm status", IDX_STATUS, 8'h20);
    outs("nvm req", 3'h6);
    apb(1'h1, IDX_FLAGS2, 8'h00);
    outs("nvm clr", 3'h2);
    $display("test nvm done");
  endtask
  // last pass drops the select: pin zero must count as a port change
  task t_ext;
    logic [1:0] c;
    for (int i = 0; i < 5; i++) begin
      c = i[1:0];
      apb(1'h1, IDX_EDGE, {3'h0, !i[2], 2'h0, c});
      for (int f = 0; f < 2; f++) begin
        apb(1'h1, IDX_FLAGS, 8'h00);
        pb[0] <= !f[0];
        rdc("edge", IDX_FLAGS, i[2] ? 8'h02 : {5'h0, c[f], 2'h0});
        chk("ext sel", pzExt, !i[2]);
      end
    end
    $display("test ext done");
  endtask
  // pb bit 1 is high here, so a missing priming sample after the
  // second reset would show up as a port change flag
  task t_midreset;
    outs("before reset", 3'h6);
    sys_rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'h0;
    outs("reset outs", 3'h0);
    rdc("enable", IDX_ENABLE, 8'h00);
    rdc("enable2", IDX_ENABLE2, 8'h00);
    rdc("edge", IDX_EDGE, 8'h01);
    apb(1'h1, IDX_ENABLE, 8'hff);
    apb(1'h1, IDX_ENABLE2, 8'hff);
    rdc("flags", IDX_FLAGS, 8'h00);
    rdc("flags2", IDX_FLAGS2, 8'h00);
    rdc("status", IDX_STATUS, 8'h00);
    $display("test second reset done");
  endtask
  // with the enable low an event pulse must leave no trace
  task t_hold;
    clkEn <= 1'h0;
    pulse(5'h01);
    @(posedge ref_clk);
    clkEn <= 1'h1;
    rdc("frozen", IDX_FLAGS, 8'h00);
    pulse(5'h01);
    rdc("tmr a", IDX_FLAGS, 8'h01);
    $display("test hold done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'h0;
    t_reset;
    t_flags;
    t_nvm;
    t_ext;
    t_midreset;
    t_hold;
    close_out;
  end
  // the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    close_out;
  end
endmodule
bind mcu_interrupt_enable_flag_unit irq_unit_asserts u_asserts (.ref_clk,
  .sys_rst, .clkEn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .coreIrqReq, .irq, .portbPinZeroExt);
`default_nettype wire
